// file: rtl/bridge_secondary_cfg_defs.vh
// Constants of the secondary-side configuration registers of the bridge.
// Assumes byte addresses of configuration dwords; included by bare name.
`ifndef BRIDGE_SECONDARY_CFG_DEFS_VH
`define BRIDGE_SECONDARY_CFG_DEFS_VH

// ****************************************************************
// Dword addresses
// ****************************************************************
`define ADDR_BUS_NUMBERS        8'h18
`define ADDR_IO_AND_STATUS      8'h1C

// ****************************************************************
// Field positions and fixed values
// ****************************************************************
`define LAT_LSB                 24
`define IO_CAP_32BIT            4'h1
`define IO_BASE_LSB             4
`define IO_LIMIT_LSB            12
`define STAT_66MHZ              21
`define STAT_FAST_B2B           23
`define STAT_DATA_PAR           24
`define STAT_DEVSEL_LSB         25
`define DEVSEL_MEDIUM           2'h1
`define STAT_SIG_TABORT         27
`define STAT_RCV_TABORT         28
`define STAT_RCV_MABORT         29
`define STAT_RCV_SERR           30
`define STAT_DET_PERR           31

// ****************************************************************
// Reset values
// ****************************************************************
`define LAT_RESET               8'h00
`define IO_FIELD_RESET          4'h0

`endif

// file: rtl/w1c_event_bit.v
// One sticky status bit that hardware sets and software clears by writing 1.
// Assumes the set and clear strobes are synchronous one-cycle levels.
`timescale 1ns/1ps

module w1c_event_bit (
    input  wire clk,
    input  wire nrst,
    input  wire set_event,
    input  wire clear_req,
    output reg  flag
);

    // ****************************************************************
    // Sticky flag, set wins over a clear in the same cycle
    // ****************************************************************
    always @(posedge clk) begin
        if (!nrst) begin
            flag <= 1'b0;
        end else if (set_event) begin
            flag <= 1'b1;
        end else if (clear_req) begin
            flag <= 1'b0;
        end
    end

endmodule

// file: rtl/latency_timer.v
// Secondary master latency counter.
// Assumes frame_start pulses when the bridge asserts its secondary frame.
`timescale 1ns/1ps

module latency_timer #(
    parameter WIDTH = 8
) (
    input  wire             clk,
    input  wire             nrst,
    input  wire [WIDTH-1:0] preset,
    input  wire             frame_start,
    input  wire             master_active,
    output wire             expired
);

    reg  [WIDTH-1:0] count;
    reg              running;

    // ****************************************************************
    // Count clocks from frame assertion; one-cycle granularity
    // ****************************************************************
    always @(posedge clk) begin
        if (!nrst) begin
            count   <= {WIDTH{1'b0}};
            running <= 1'b0;
        end else if (frame_start) begin
            count   <= preset;
            running <= 1'b1;
        end else if (!master_active) begin
            running <= 1'b0;
        end else if (running && count != {WIDTH{1'b0}}) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    // Zero preset expires at once, so the first data phase ends it
    assign expired = running && (count == {WIDTH{1'b0}});

endmodule

// file: rtl/bridge_secondary_cfg_regs.v
// Secondary latency timer, I/O window low halves and secondary status.
// Assumes a configuration port with dword address, byte enables and
// single-cycle read and write strobes, plus event pulses from the
// secondary bus engine; all inputs synchronous to clk.
`timescale 1ns/1ps
`include "bridge_secondary_cfg_defs.vh"

// Notes on behaviour
// RULE_01 - Eight-bit writable latency timer counts clocks from secondary frame assertion.
// RULE_02 - Timer zero and grant withdrawn ends transfer after first data phase, except MWI.
// RULE_03 - Nonzero timer expired with grant gone ends transfer at next data-phase boundary.
// RULE_04 - I/O base low nibble is read-only and returns 0x1.
// RULE_05 - I/O limit low nibble is read-only and returns 0x1.
// RULE_06 - Writable I/O base gives address bits 15:12; lower bits zero, 4 kB aligned.
// RULE_07 - Writable I/O limit gives address bits 15:12 of window top.
// RULE_08 - Address bits 31:16 of both come from the upper I/O register.
// RULE_09 - Status event bits clear on writing 1; writing 0 leaves them.
// RULE_10 - Status bits 20:16 and 22 read as zero.
// RULE_11 - Status bit 21 follows the 66 MHz capability strap pin.
// RULE_12 - Status bit 23 always reads 1 for fast back-to-back.
// RULE_13 - Bit 24 sets when master, parity error seen, and parity response enabled.
// RULE_14 - Device-select timing field reads binary 01, medium timing.
// RULE_15 - Bit 27 sets when bridge as target signals target abort.
// RULE_16 - Bit 28 sets when bridge as master receives target abort.
// RULE_17 - Bit 29 sets when bridge as initiator receives master abort.
// RULE_18 - Bit 30 sets when secondary system error signal is seen asserted.
// RULE_19 - Bit 31 sets on address or data parity error on secondary side.
module bridge_secondary_cfg_regs #(
    parameter LAT_WIDTH = 8
) (
    input  wire        clk,
    input  wire        nrst,
    // Configuration access port
    input  wire [7:0]  cfg_addr,
    input  wire [3:0]  cfg_byte_en_n,
    input  wire        cfg_write,
    input  wire        cfg_read,
    input  wire [31:0] cfg_wdata,
    output reg  [31:0] cfg_rdata,
    // Upper I/O address halves, held elsewhere
    input  wire [15:0] io_base_upper,
    input  wire [15:0] io_limit_upper,
    // Secondary master sequencing
    input  wire        sec_frame_start,
    input  wire        sec_master_active,
    input  wire        sec_grant,
    input  wire        sec_data_phase_done,
    input  wire        sec_mem_write_inval,
    output wire        sec_master_stop,
    // I/O window decode
    input  wire [31:0] io_addr,
    output wire        io_addr_in_window,
    output wire [31:0] io_window_bottom,
    output wire [31:0] io_window_top,
    // Status events
    input  wire        speed_capability_strap,
    input  wire        secondary_parity_err_n,
    input  wire        primary_parity_err,
    input  wire        parity_response_en,
    input  wire        sec_target_abort_sent,
    input  wire        sec_target_abort_rcvd,
    input  wire        sec_master_abort_rcvd,
    input  wire        secondary_system_err_n,
    input  wire        sec_addr_parity_err,
    input  wire        sec_data_parity_err
);

    reg  [LAT_WIDTH-1:0] secondary_master_latency_timer;
    reg  [3:0]           io_base_field;
    reg  [3:0]           io_limit_field;
    reg                  strap_seen;
    wire                 lat_expired;
    wire [7:0]           io_window_base_low;
    wire [7:0]           io_window_limit_low;
    wire [15:0]          secondary_side_status;
    wire [4:0]           event_set;
    wire [4:0]           event_clear;
    wire [4:0]           event_flag;
    wire                 par_set;
    wire                 par_clear;
    wire                 par_flag;
    wire                 wr_18;
    wire                 wr_1c;

    // ****************************************************************
    // Address and byte-lane decode
    // ****************************************************************
    function lane_write;
        input [7:0] addr;
        input [7:0] target;
        input [3:0] be_n;
        input [1:0] lane;
        begin
            lane_write = (addr == target) && !be_n[lane];
        end
    endfunction

    assign wr_18 = cfg_write && lane_write(cfg_addr, `ADDR_BUS_NUMBERS, cfg_byte_en_n, 2'h3);
    assign wr_1c = cfg_write && (cfg_addr == `ADDR_IO_AND_STATUS);

    // ****************************************************************
    // Writable fields
    // ****************************************************************
    always @(posedge clk) begin
        if (!nrst) begin
            secondary_master_latency_timer <= `LAT_RESET;
            io_base_field                  <= `IO_FIELD_RESET;
            io_limit_field                 <= `IO_FIELD_RESET;
        end else begin
            if (wr_18) begin
                // All timer bits writable [RULE_01]
                secondary_master_latency_timer <= cfg_wdata[`LAT_LSB +: LAT_WIDTH];
            end
            if (wr_1c && !cfg_byte_en_n[0]) begin
                io_base_field <= cfg_wdata[`IO_BASE_LSB +: 4]; // [RULE_06]
            end
            if (wr_1c && !cfg_byte_en_n[1]) begin
                io_limit_field <= cfg_wdata[`IO_LIMIT_LSB +: 4]; // [RULE_07]
            end
        end
    end

    // ****************************************************************
    // Latency timer and master stop
    // ****************************************************************
    latency_timer #(
        .WIDTH (LAT_WIDTH)
    ) u_latency_timer (
        .clk           (clk),
        .nrst          (nrst),
        .preset        (secondary_master_latency_timer),
        .frame_start   (sec_frame_start),
        .master_active (sec_master_active),
        .expired       (lat_expired)
    );

    // Stop at the boundary once expired with grant gone; MWI runs on at zero
    assign sec_master_stop = sec_master_active && lat_expired && !sec_grant
                             && sec_data_phase_done
                             && !(sec_mem_write_inval
                                  && secondary_master_latency_timer == {LAT_WIDTH{1'b0}}); // [RULE_02] [RULE_03]

    // ****************************************************************
    // I/O forwarding window
    // ****************************************************************
    assign io_window_base_low  = {io_base_field, `IO_CAP_32BIT};  // [RULE_04]
    assign io_window_limit_low = {io_limit_field, `IO_CAP_32BIT}; // [RULE_05]
    // Upper halves from the upper I/O registers, 4 kB granularity
    assign io_window_bottom = {io_base_upper, io_base_field, 12'h000};   // [RULE_06] [RULE_08]
    assign io_window_top    = {io_limit_upper, io_limit_field, 12'hFFF}; // [RULE_07] [RULE_08]
    assign io_addr_in_window = (io_addr >= io_window_bottom) && (io_addr <= io_window_top);

    // ****************************************************************
    // Strap sampled on every clock after reset release
    // ****************************************************************
    always @(posedge clk) begin
        if (!nrst) begin
            strap_seen <= 1'b0;
        end else begin
            strap_seen <= speed_capability_strap; // [RULE_11]
        end
    end

    // ****************************************************************
    // Status events
    // ****************************************************************
    assign par_set = sec_master_active && parity_response_en
                     && (!secondary_parity_err_n || primary_parity_err); // [RULE_13]
    assign event_set = {sec_addr_parity_err || sec_data_parity_err, // [RULE_19]
                        !secondary_system_err_n,                    // [RULE_18]
                        sec_master_abort_rcvd,                      // [RULE_17]
                        sec_target_abort_rcvd,                      // [RULE_16]
                        sec_target_abort_sent};                     // [RULE_15]
    // Clear on write of one to the upper lane [RULE_09]
    assign par_clear = wr_1c && !cfg_byte_en_n[3] && cfg_wdata[`STAT_DATA_PAR];
    assign event_clear = (wr_1c && !cfg_byte_en_n[3]) ?
                         cfg_wdata[`STAT_DET_PERR:`STAT_SIG_TABORT] : 5'h00;

    w1c_event_bit u_par_bit (
        .clk       (clk),
        .nrst      (nrst),
        .set_event (par_set),
        .clear_req (par_clear),
        .flag      (par_flag)
    );

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi = gi + 1) begin : g_event
            w1c_event_bit u_bit (
                .clk       (clk),
                .nrst      (nrst),
                .set_event (event_set[gi]),
                .clear_req (event_clear[gi]),
                .flag      (event_flag[gi])
            );
        end
    endgenerate

    // Status word, bits 31:16 of the dword
    assign secondary_side_status = {event_flag,      // 31:27
                                    `DEVSEL_MEDIUM,  // [RULE_14]
                                    par_flag,        // [RULE_13]
                                    1'b1,            // [RULE_12]
                                    1'b0,            // [RULE_10]
                                    strap_seen,      // [RULE_11]
                                    5'h00};          // [RULE_10]

    // ****************************************************************
    // Read data register
    // ****************************************************************
    always @(posedge clk) begin
        if (!nrst) begin
            cfg_rdata <= 32'h00000000;
        end else if (cfg_read) begin
            case (cfg_addr)
                `ADDR_BUS_NUMBERS: begin
                    cfg_rdata <= {secondary_master_latency_timer, 24'h000000};
                end
                `ADDR_IO_AND_STATUS: begin
                    cfg_rdata <= {secondary_side_status, io_window_limit_low,
                                  io_window_base_low};
                end
                default: begin
                    cfg_rdata <= 32'h00000000;
                end
            endcase
        end
    end

endmodule

// file: sim/sec_bus_agent.sv
// Model of the secondary bus agents that raise error and abort events.
// Assumes fire is a one-cycle request and kind selects the event line.
`timescale 1ns/1ps

// ****************************************************************
// Secondary bus agent
// ****************************************************************
module sec_bus_agent (
    input  wire       clk,
    input  wire       fire,
    input  wire [2:0] kind,
    output wire       secondary_parity_err_n,
    output wire       sec_target_abort_sent,
    output wire       sec_target_abort_rcvd,
    output wire       sec_master_abort_rcvd,
    output wire       secondary_system_err_n,
    output wire       sec_addr_parity_err,
    output wire       sec_data_parity_err
);
    reg [6:0] ev = 7'h00;
    // One event per request, lasting exactly one cycle
    always @(posedge clk) begin
        ev <= fire ? (7'h01 << kind) : 7'h00;
    end
    // Active-low error lines rest high, inverted from their event bits
    assign {sec_data_parity_err, sec_addr_parity_err, secondary_system_err_n,
            sec_master_abort_rcvd, sec_target_abort_rcvd, sec_target_abort_sent,
            secondary_parity_err_n} = ev ^ 7'h11;
endmodule

// file: sim/bridge_secondary_cfg_checker.sv
// Assertions on the secondary configuration register bank.
// Assumes it is bound to the bank by name; reads answer one cycle later.
`timescale 1ns/1ps

// ****************************************************************
// Checker
// ****************************************************************
module bridge_secondary_cfg_checker #(
    parameter LAT_WIDTH = 8
) (
    input wire        clk,
    input wire        nrst,
    input wire [7:0]  cfg_addr,
    input wire [3:0]  cfg_byte_en_n,
    input wire        cfg_write,
    input wire        cfg_read,
    input wire [31:0] cfg_wdata,
    input wire [31:0] cfg_rdata,
    input wire [15:0] io_base_upper,
    input wire [15:0] io_limit_upper,
    input wire        sec_master_active,
    input wire        sec_grant,
    input wire        sec_data_phase_done,
    input wire        sec_master_stop,
    input wire [31:0] io_addr,
    input wire        io_addr_in_window,
    input wire [31:0] io_window_bottom,
    input wire [31:0] io_window_top,
    input wire        speed_capability_strap,
    input wire        secondary_parity_err_n,
    input wire        primary_parity_err,
    input wire        parity_response_en,
    input wire        sec_target_abort_sent,
    input wire        sec_target_abort_rcvd,
    input wire        sec_master_abort_rcvd,
    input wire        secondary_system_err_n,
    input wire        sec_addr_parity_err,
    input wire        sec_data_parity_err
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Decoded accesses and quiet parity lines
    wire rd1c = cfg_read && cfg_addr == 8'h1C;
    wire no31 = !sec_addr_parity_err && !sec_data_parity_err;
    sequence clr31;
        cfg_write && cfg_addr == 8'h1C && !cfg_byte_en_n[3] && cfg_wdata[31];
    endsequence
    sequence lat_wr;
        cfg_write && cfg_addr == 8'h18 && !cfg_byte_en_n[3];
    endsequence
    property sets_bit(ev, int b);
        ev ##1 rd1c |=> cfg_rdata[b];
    endproperty

    fixed_bits_a: assert property (rd1c |=> (cfg_rdata & 32'h06DF0F0F) == 32'h02800101)
        else $error("fixed status or indicator bits wrong");
    strap_bit_a: assert property (rd1c && $past(nrst) && $stable(speed_capability_strap)
        |=> cfg_rdata[21] == $past(speed_capability_strap)) else $error("strap bit wrong");
    win_edges_a: assert property (io_window_bottom == {io_base_upper, io_window_bottom[15:12],
        12'h000} && io_window_top == {io_limit_upper, io_window_top[15:12], 12'hFFF})
        else $error("window edges wrong");
    win_match_a: assert property (io_addr_in_window ==
        (io_addr >= io_window_bottom && io_addr <= io_window_top)) else $error("window match wrong");
    perr_set_a: assert property (sets_bit(sec_master_active && parity_response_en &&
        (!secondary_parity_err_n || primary_parity_err), 24)) else $error("bit 24 not set");
    tabort_sig_a: assert property (sets_bit(sec_target_abort_sent, 27))
        else $error("bit 27 not set");
    tabort_rcv_a: assert property (sets_bit(sec_target_abort_rcvd, 28))
        else $error("bit 28 not set");
    mabort_rcv_a: assert property (sets_bit(sec_master_abort_rcvd, 29))
        else $error("bit 29 not set");
    serr_rcv_a: assert property (sets_bit(!secondary_system_err_n, 30))
        else $error("bit 30 not set");
    perr_det_a: assert property (sets_bit(!no31, 31))
        else $error("bit 31 not set");
    w1c_clear_a: assert property (clr31 ##0 no31 ##1 no31 ##1 rd1c |=> !cfg_rdata[31])
        else $error("bit 31 not cleared");
    timer_rw_a: assert property (lat_wr ##2 cfg_read && cfg_addr == 8'h18
        |=> cfg_rdata == ($past(cfg_wdata, 3) & 32'hFF000000)) else $error("timer readback wrong");
    stop_cause_a: assert property (sec_master_stop |-> sec_master_active && !sec_grant
        && sec_data_phase_done) else $error("stop without cause");
endmodule

bind bridge_secondary_cfg_regs bridge_secondary_cfg_checker #(.LAT_WIDTH(LAT_WIDTH)) chk (.*);

// file: sim/bridge_secondary_cfg_regs_tb.sv
// Self-checking bench for the secondary configuration register bank.
// Assumes the checker binds itself and the bus agent supplies events.
`timescale 1ns/1ps

// ****************************************************************
// Testbench
// ****************************************************************
module bridge_secondary_cfg_regs_tb;
    reg         clk = 1'b0, nrst = 1'b0, cfg_write = 1'b0, cfg_read = 1'b0, fire = 1'b0;
    reg  [7:0]  cfg_addr = 8'h00;
    reg  [3:0]  cfg_byte_en_n = 4'hF;
    reg  [2:0]  kind = 3'h0;
    reg  [31:0] cfg_wdata = 32'h0, io_addr = 32'h0, d;
    reg  [15:0] io_base_upper = 16'h1234, io_limit_upper = 16'h5678;
    reg         sec_frame_start = 1'b0, sec_master_active = 1'b0, sec_grant = 1'b1;
    reg         sec_data_phase_done = 1'b0, sec_mem_write_inval = 1'b0;
    reg         speed_capability_strap = 1'b1, primary_parity_err = 1'b0;
    reg         parity_response_en = 1'b1;
    wire [31:0] cfg_rdata, io_window_bottom, io_window_top;
    wire        sec_master_stop, io_addr_in_window, secondary_parity_err_n;
    wire        sec_target_abort_sent, sec_target_abort_rcvd, sec_master_abort_rcvd;
    wire        secondary_system_err_n, sec_addr_parity_err, sec_data_parity_err;
    integer     mismatches = 0, cmp_count = 0, i, k, b;

    bridge_secondary_cfg_regs uut (.*);
    sec_bus_agent agent (.*);

    // Free-running clock and watchdog
    initial forever #50 clk = ~clk;
    initial begin
        #5000000 mismatches = mismatches + 1;
        complete_run;
    end

    task automatic check(input [31:0] seen, input [31:0] exp);
        cmp_count = cmp_count + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic cfg_wr(input [7:0] a, input [3:0] be, input [31:0] v);
        @(posedge clk) {cfg_addr, cfg_byte_en_n, cfg_wdata, cfg_write} <= {a, be, v, 1'b1};
        @(posedge clk) cfg_write <= 1'b0;
    endtask
    task automatic cfg_rd(input [7:0] a, output [31:0] v);
        @(posedge clk) {cfg_addr, cfg_read} <= {a, 1'b1};
        @(posedge clk) cfg_read <= 1'b0;
        #1 v = cfg_rdata;
    endtask
    task automatic raise(input [2:0] kd);
        @(posedge clk) {fire, kind} <= {1'b1, kd};
        @(posedge clk) fire <= 1'b0;
    endtask
    task automatic win(input [31:0] a, input exp);
        @(posedge clk) io_addr <= a;
        @(posedge clk) #1 check(io_addr_in_window, exp);
    endtask
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (16) @(posedge clk);
        nrst <= 1'b1;
        cfg_rd(8'h18, d); check(d, 32'h0);
        cfg_rd(8'h1C, d); check(d, 32'h02A00101);
        cfg_wr(8'h1C, 4'h0, 32'hFFFFFFFF);
        cfg_rd(8'h1C, d); check(d, 32'h02A0F1F1);
        cfg_wr(8'h1C, 4'hE, 32'h00000030);
        cfg_rd(8'h1C, d); check(d, 32'h02A0F131);
        check(io_window_bottom, 32'h12343000);
        check(io_window_top, 32'h5678FFFF);
        win(32'h12342FFF, 0); win(32'h12343000, 1); win(32'h5678FFFF, 1); win(32'h56790000, 0);
        cfg_wr(8'h18, 4'h7, 32'hA5FFFFFF);
        cfg_rd(8'h18, d); check(d, 32'hA5000000);
        cfg_wr(8'h20, 4'h0, 32'hFFFFFFFF);
        cfg_rd(8'h20, d); check(d, 32'h0);
        $display("test registers done");
        // Every event sets its bit, survives a zero write, clears on a one
        @(posedge clk) sec_master_active <= 1'b1;
        for (k = 0; k < 7; k = k + 1) begin
            b = (k == 0) ? 24 : ((k > 4) ? 31 : 26 + k);
            raise(k);
            cfg_rd(8'h1C, d); check(d[b], 1);
            cfg_wr(8'h1C, 4'h7, 32'h0);
            cfg_rd(8'h1C, d); check(d[b], 1);
            cfg_wr(8'h1C, 4'h7, 32'h1 << b);
            cfg_rd(8'h1C, d); check(d[b], 0);
        end
        @(posedge clk) parity_response_en <= 1'b0;
        raise(0);
        cfg_rd(8'h1C, d); check(d[24], 0);
        @(posedge clk) {parity_response_en, sec_master_active} <= 2'b10;
        raise(0);
        cfg_rd(8'h1C, d); check(d[24], 0);
        @(posedge clk) {sec_master_active, primary_parity_err} <= 2'b11;
        @(posedge clk) primary_parity_err <= 1'b0;
        cfg_rd(8'h1C, d); check(d[24], 1);
        @(posedge clk) speed_capability_strap <= 1'b0;
        cfg_rd(8'h1C, d); check(d[21], 0);
        $display("test status done");
        // Master stop at timer expiry, with and without the invalidate exemption
        for (k = 0; k < 4; k = k + 1) begin
            cfg_wr(8'h18, 4'h7, (k >> 1) << 25);
            @(posedge clk) {sec_grant, sec_data_phase_done, sec_mem_write_inval} <= {2'b01, k[0]};
            sec_frame_start <= 1'b1;
            @(posedge clk) sec_frame_start <= 1'b0;
            for (i = 0; i < 4; i = i + 1) begin
                #1 check(sec_master_stop, i >= (k >> 1) * 2 && !(k == 1));
                @(posedge clk);
            end
            sec_grant <= 1'b1;
            @(posedge clk) #1 check(sec_master_stop, 0);
        end
        $display("test timer done");
        complete_run;
    end
endmodule
